// file: skip_test_regs.vh
// Register offsets, field positions, reset values and opcodes of the skip-test unit.
`ifndef SKIP_TEST_REGS_VH
`define SKIP_TEST_REGS_VH

// Register word offsets on the plain register port.
`define ADDR_IRQ_CONTROL_FIRST 4'h0
`define ADDR_IRQ_CONTROL_SECOND 4'h1
`define ADDR_IRQ_PIN_CONTROL 4'h2
`define ADDR_REQUEST_STATUS 4'h3
`define ADDR_REQUEST_MASK 4'h4
`define ADDR_UNIT_STATE 4'h5

// Field positions.
`define BIT_EXT_IRQ_ENABLE 0
`define BIT_TIMER_ONE_IRQ_ENABLE 2
`define BIT_TIMER_TWO_IRQ_ENABLE 3
`define BIT_CONVERTER_IRQ_ENABLE 2
`define BIT_PIN_POLARITY_SELECT 2

// Request flag positions in the status and mask registers.
`define FLAG_EXT 0
`define FLAG_CONV 1
`define FLAG_TIMER_ONE 2
`define FLAG_TIMER_TWO 3

// Reset values.
`define RESET_NIBBLE 4'h0

// Ten-bit opcodes of the skip-test instructions.
`define OP_SKIP_IF_ACC_EQUALS_MEM 10'h026
`define OP_SKIP_ON_EXT_REQUEST 10'h038
`define OP_SKIP_ON_CONVERSION_DONE 10'h287
`define OP_SKIP_ON_PORTC_HIGH 10'h289
`define OP_SKIP_ON_IRQ_PIN_LEVEL 10'h03A
`define OP_SKIP_ON_POWERDOWN_FLAG 10'h003
`define OP_SKIP_ON_TIMER_ONE_REQUEST 10'h280
`define OP_SKIP_ON_TIMER_TWO_REQUEST 10'h281

`endif

// file: skip_test_instruction_unit.v
// Skip decision logic for the conditional skip-test instructions of the core.
//
// Summary of operation
// RQ1: Skip next when accumulator equals addressed nibble.
// RQ2: Ext enable zero: skip on ext flag, clear it.
// RQ3: Ext enable one: ext test is no-operation.
// RQ4: Ext flag clear: no skip, flag unchanged.
// RQ5: Converter enable zero: skip on done flag, clear.
// RQ6: Converter enable one: done test is no-operation.
// RQ7: Port C test skips when port C reads one.
// RQ8: Polarity zero: pin test skips on low pin.
// RQ9: Polarity one: pin test skips on high pin.
// RQ10: Power-down test skips on flag, never clears.
// RQ11: Timer one enable zero: skip on flag, clear.
// RQ12: Timer one enable one: timer one test no-operation.
// RQ13: Timer two enable zero: skip on flag set.
// RQ14: Timer two skip clears flag; enable one no-operation.
// RQ15: Skipped instruction is fetched but has no effect.
`timescale 1ns/10ps
`include "skip_test_regs.vh"

module skip_test_instruction_unit (
    // Core instruction clock, 10 MHz.
    input wire clock,
    // Synchronous reset, active low.
    input wire reset_n,
    // One-cycle pulse: an instruction word is presented this cycle.
    input wire instr_valid,
    // The instruction word being executed.
    input wire [9:0] instr_code,
    // Accumulator contents.
    input wire [3:0] acc,
    // Data-memory nibble selected by the data pointer.
    input wire [3:0] mem_nibble,
    // One-cycle set pulses from the request sources.
    input wire ext_request_set,
    input wire conversion_done_set,
    input wire timer_one_request_set,
    input wire timer_two_request_set,
    // Power-down flag held by the core power logic.
    input wire powerdown_flag,
    // Port C pin level, asynchronous.
    input wire portc_pin,
    // External interrupt pin level, asynchronous.
    input wire irq_pin,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [3:0] reg_rdata_q,
    // High while the next instruction must be suppressed.
    output reg skip_q,
    // Request flags, for the interrupt controller.
    output reg ext_request_flag_q,
    output reg conversion_done_flag_q,
    output reg timer_one_request_flag_q,
    output reg timer_two_request_flag_q,
    // Level interrupt, high while an unmasked request flag is set.
    output reg irq_q
);

    // Control registers written by software.
    reg [3:0] irq_control_first_q;
    reg [3:0] irq_control_second_q;
    reg [3:0] irq_pin_control_q;
    // Mask that gates the request flags onto the interrupt output.
    reg [3:0] request_mask_q;

    // Two-stage synchronisers for the pins; stage one is read only by stage two.
    // Bit 0 carries port C, bit 1 the external interrupt pin.
    reg [1:0] pin_meta_q;
    reg [1:0] pin_sync_q;

    // Request flags as a vector, so one loop handles them all.
    reg [3:0] flag_q;
    wire [3:0] flag_d;
    wire [3:0] flag_set;
    // Clear requested by a taken skip.
    reg [3:0] skip_clear;
    // Clear requested by a one written to the status register.
    wire [3:0] sw_clear;

    // Combinational decode results.
    reg skip_hit;
    reg skip_d;

    // Aliases of the enable and select fields and of the synchronised pin levels.
    wire ext_irq_enable_bit;
    wire timer_one_irq_enable_bit;
    wire timer_two_irq_enable_bit;
    wire converter_irq_enable_bit;
    wire pin_polarity_select_bit;
    wire portc_level;
    wire irq_pin_level;

    // An instruction that is itself being skipped must have no effect at all.
    wire live_instr;

    // Next read data.
    reg [3:0] rdata_d;

    assign ext_irq_enable_bit = irq_control_first_q[`BIT_EXT_IRQ_ENABLE];
    assign timer_one_irq_enable_bit = irq_control_first_q[`BIT_TIMER_ONE_IRQ_ENABLE];
    assign timer_two_irq_enable_bit = irq_control_first_q[`BIT_TIMER_TWO_IRQ_ENABLE];
    assign converter_irq_enable_bit = irq_control_second_q[`BIT_CONVERTER_IRQ_ENABLE];
    assign pin_polarity_select_bit = irq_pin_control_q[`BIT_PIN_POLARITY_SELECT];
    assign portc_level = pin_sync_q[0];
    assign irq_pin_level = pin_sync_q[1];

    // A pending skip swallows the next instruction word.
    // The core still fetches it and advances the counter; only its effect is dropped.
    assign live_instr = instr_valid & ~skip_q; // RQ15

    // Set pulses come from logic on this clock, so they need no synchroniser.
    assign flag_set[`FLAG_EXT] = ext_request_set;
    assign flag_set[`FLAG_CONV] = conversion_done_set;
    assign flag_set[`FLAG_TIMER_ONE] = timer_one_request_set;
    assign flag_set[`FLAG_TIMER_TWO] = timer_two_request_set;

    // Software clear only acts on a write to the status register.
    // A zero bit in the written word leaves that flag alone.
    assign sw_clear = (reg_write && reg_addr == `ADDR_REQUEST_STATUS) ? reg_wdata : 4'h0;

    // Pin synchronisers; the pins are sampled twice before anything reads them.
    // The pins may change at any moment, so stage one may be caught unsettled.
    always @(posedge clock) begin
        if (!reset_n) begin
            // Both stages start low, so the tests see low pins right after reset.
            pin_meta_q <= 2'h0;
            pin_sync_q <= 2'h0;
        end else begin
            // Stage two is the only reader of stage one.
            pin_meta_q <= {irq_pin, portc_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Skip decision and flag clears for the current instruction.
    always @* begin
        skip_hit = 1'b0;
        skip_clear = 4'h0;
        if (live_instr) begin
            case (instr_code)
                `OP_SKIP_IF_ACC_EQUALS_MEM: begin
                    // One word, one cycle; equality alone decides.
                    skip_hit = (acc == mem_nibble); // RQ1
                end
                `OP_SKIP_ON_EXT_REQUEST: begin
                    // With the enable set the word is a plain no-operation.
                    if (!ext_irq_enable_bit) begin // RQ3
                        skip_hit = flag_q[`FLAG_EXT]; // RQ2
                        // A clear flag leaves the flag untouched.
                        skip_clear[`FLAG_EXT] = flag_q[`FLAG_EXT]; // RQ4
                    end
                end
                `OP_SKIP_ON_CONVERSION_DONE: begin
                    // Enable set: no-operation.
                    if (!converter_irq_enable_bit) begin // RQ6
                        skip_hit = flag_q[`FLAG_CONV]; // RQ5
                        skip_clear[`FLAG_CONV] = flag_q[`FLAG_CONV]; // RQ5
                    end
                end
                `OP_SKIP_ON_PORTC_HIGH: begin
                    // The level is two clocks old; software must allow for that.
                    skip_hit = portc_level; // RQ7
                end
                `OP_SKIP_ON_IRQ_PIN_LEVEL: begin
                    // Polarity select chooses which level counts.
                    if (pin_polarity_select_bit) begin
                        // Polarity one: a high pin skips.
                        skip_hit = irq_pin_level; // RQ9
                    end else begin
                        // Polarity zero: a low pin skips.
                        skip_hit = ~irq_pin_level; // RQ8
                    end
                end
                `OP_SKIP_ON_POWERDOWN_FLAG: begin
                    // The power-down flag is only looked at, never cleared.
                    skip_hit = powerdown_flag; // RQ10
                end
                `OP_SKIP_ON_TIMER_ONE_REQUEST: begin
                    // Enable set: no-operation, the flag waits for the interrupt.
                    if (!timer_one_irq_enable_bit) begin // RQ12
                        skip_hit = flag_q[`FLAG_TIMER_ONE]; // RQ11
                        skip_clear[`FLAG_TIMER_ONE] = flag_q[`FLAG_TIMER_ONE]; // RQ11
                    end
                end
                `OP_SKIP_ON_TIMER_TWO_REQUEST: begin
                    // Same shape as the timer one test.
                    if (!timer_two_irq_enable_bit) begin // RQ14
                        skip_hit = flag_q[`FLAG_TIMER_TWO]; // RQ13
                        skip_clear[`FLAG_TIMER_TWO] = flag_q[`FLAG_TIMER_TWO]; // RQ14
                    end
                end
                default: begin
                    // Any other instruction never skips here.
                    skip_hit = 1'b0;
                end
            endcase
        end
    end

    // Skip state: set by a taken test, consumed by the next instruction word.
    always @* begin
        // Without a word the pending skip simply waits.
        skip_d = skip_q;
        if (instr_valid) begin
            // The swallowed word cannot start a new skip of its own.
            // Two taken tests in a row therefore skip one word, not two.
            skip_d = skip_q ? 1'b0 : skip_hit; // RQ15
        end
    end

    // Skip flip-flop; held until the core presents the next word.
    always @(posedge clock) begin
        if (!reset_n) begin
            // The first word after reset always runs.
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    // Request flags; a set arriving with any clear wins, so no event is lost.
    // The same next-state equation serves every flag, so one loop builds them all.
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_flag
            // Set pulse first; otherwise hold unless a skip or software clears it.
            assign flag_d[i] = flag_set[i] | (flag_q[i] & ~skip_clear[i] & ~sw_clear[i]);
        end
    endgenerate

    // One process owns the whole flag vector, so each bit has a single driver.
    always @(posedge clock) begin
        if (!reset_n) begin
            // No request survives a reset.
            flag_q <= 4'h0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Flag outputs and the interrupt line, each straight from a flip-flop.
    always @(posedge clock) begin
        if (!reset_n) begin
            // All outputs low during reset.
            ext_request_flag_q <= 1'b0;
            conversion_done_flag_q <= 1'b0;
            timer_one_request_flag_q <= 1'b0;
            timer_two_request_flag_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            // Next values, so these outputs match the status register bits.
            ext_request_flag_q <= flag_d[`FLAG_EXT];
            conversion_done_flag_q <= flag_d[`FLAG_CONV];
            timer_one_request_flag_q <= flag_d[`FLAG_TIMER_ONE];
            timer_two_request_flag_q <= flag_d[`FLAG_TIMER_TWO];
            // Built from the next flag value so it tracks the flag outputs.
            irq_q <= |(flag_d & request_mask_q);
        end
    end

    // Control register writes.
    always @(posedge clock) begin
        if (!reset_n) begin
            // Enables, polarity and mask all come up as zero.
            irq_control_first_q <= `RESET_NIBBLE;
            irq_control_second_q <= `RESET_NIBBLE;
            irq_pin_control_q <= `RESET_NIBBLE;
            request_mask_q <= `RESET_NIBBLE;
        end else if (reg_write) begin
            case (reg_addr)
                `ADDR_IRQ_CONTROL_FIRST: begin
                    // External, timer one and timer two enables.
                    irq_control_first_q <= reg_wdata;
                end
                `ADDR_IRQ_CONTROL_SECOND: begin
                    // Converter enable.
                    irq_control_second_q <= reg_wdata;
                end
                `ADDR_IRQ_PIN_CONTROL: begin
                    // Pin polarity select.
                    irq_pin_control_q <= reg_wdata;
                end
                `ADDR_REQUEST_MASK: begin
                    // Gates the flags onto the interrupt line from the next cycle.
                    request_mask_q <= reg_wdata;
                end
                default: begin
                    // Status clears are handled with the flags; others ignored.
                    request_mask_q <= request_mask_q;
                end
            endcase
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    // Zero while idle, so read data stands for one cycle only.
    always @* begin
        rdata_d = 4'h0;
        if (reg_read) begin
            case (reg_addr)
                `ADDR_IRQ_CONTROL_FIRST: begin
                    rdata_d = irq_control_first_q;
                end
                `ADDR_IRQ_CONTROL_SECOND: begin
                    rdata_d = irq_control_second_q;
                end
                `ADDR_IRQ_PIN_CONTROL: begin
                    rdata_d = irq_pin_control_q;
                end
                `ADDR_REQUEST_STATUS: begin
                    // Raw flags, unmasked, so software can poll with the interrupt off.
                    rdata_d = flag_q;
                end
                `ADDR_REQUEST_MASK: begin
                    rdata_d = request_mask_q;
                end
                `ADDR_UNIT_STATE: begin
                    // Live view of what the tests look at.
                    rdata_d = {irq_pin_level, portc_level, powerdown_flag, skip_q};
                end
                default: begin
                    // Unmapped offsets read as zero.
                    rdata_d = 4'h0;
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always @(posedge clock) begin
        if (!reset_n) begin
            // No read is pending after reset.
            reg_rdata_q <= 4'h0;
        end else begin
            // Zero outside the read cycle, so a stale value never looks like data.
            reg_rdata_q <= rdata_d;
        end
    end

endmodule // skip_test_instruction_unit

// file: skip_test_asserts.sv
// Concurrent checks on the ports of the skip-test unit.
`timescale 1ns/10ps
`include "skip_test_regs.vh"
module skip_test_asserts (
    input wire clock,
    input wire reset_n,
    input wire instr_valid,
    input wire [9:0] instr_code,
    input wire [3:0] acc,
    input wire [3:0] mem_nibble,
    input wire ext_request_set,
    input wire timer_one_request_set,
    input wire powerdown_flag,
    input wire reg_write,
    input wire skip_q,
    input wire ext_request_flag_q,
    input wire conversion_done_flag_q,
    input wire timer_one_request_flag_q,
    input wire timer_two_request_flag_q
);
    // A word is acted on only when no skip is pending.
    wire live = instr_valid && !skip_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_skip_swallow: assert property (instr_valid && skip_q |=> !skip_q)
        else $error("skip did not drop on swallowed word");
    chk_swallow_keeps: assert property (
        instr_valid && skip_q && timer_one_request_flag_q
        && !reg_write |=> timer_one_request_flag_q)
        else $error("swallowed word changed a flag");
    chk_acc_equal: assert property (
        live && instr_code == `OP_SKIP_IF_ACC_EQUALS_MEM
        |=> skip_q == $past(acc == mem_nibble))
        else $error("compare skip wrong");
    chk_ext_idle: assert property (
        live && instr_code == `OP_SKIP_ON_EXT_REQUEST
        && !ext_request_flag_q |=> !skip_q)
        else $error("ext test skipped on clear flag");
    chk_ext_clear: assert property (
        live && instr_code == `OP_SKIP_ON_EXT_REQUEST
        && !ext_request_set |=> skip_q |-> !ext_request_flag_q)
        else $error("ext flag kept after skip");
    chk_conv_zero: assert property (
        live && instr_code == `OP_SKIP_ON_CONVERSION_DONE
        && !conversion_done_flag_q |=> !skip_q)
        else $error("conversion test skipped on clear flag");
    chk_t1_clear: assert property (
        live && instr_code == `OP_SKIP_ON_TIMER_ONE_REQUEST
        && !timer_one_request_set |=> skip_q |-> !timer_one_request_flag_q)
        else $error("timer one flag kept after skip");
    chk_t2_idle: assert property (
        live && instr_code == `OP_SKIP_ON_TIMER_TWO_REQUEST
        && !timer_two_request_flag_q |=> !skip_q)
        else $error("timer two test skipped on clear flag");
    chk_pd_skip: assert property (
        live && instr_code == `OP_SKIP_ON_POWERDOWN_FLAG
        |=> skip_q == $past(powerdown_flag))
        else $error("power-down skip wrong");
endmodule // skip_test_asserts

// file: skip_test_instruction_unit_tb.sv
// Self-checking bench for the skip-test unit.
`timescale 1ns/10ps
`include "skip_test_regs.vh"
module skip_test_instruction_unit_tb;
    // Row: opcode, {first, second, pin control}, set pulses, {acc, mem}, {irq, portc, pd},
    // expected {skip, flags t2 t1 conv ext}.
    typedef struct packed {
        logic [9:0] code; logic [11:0] ctl; logic [3:0] setf;
        logic [7:0] am; logic [2:0] pins; logic [4:0] exp_v;
    } row_t;
    localparam [9:0] EQ = `OP_SKIP_IF_ACC_EQUALS_MEM;
    localparam [9:0] EXT = `OP_SKIP_ON_EXT_REQUEST;
    localparam [9:0] CNV = `OP_SKIP_ON_CONVERSION_DONE;
    localparam [9:0] PC = `OP_SKIP_ON_PORTC_HIGH;
    localparam [9:0] PIN = `OP_SKIP_ON_IRQ_PIN_LEVEL;
    localparam [9:0] PD = `OP_SKIP_ON_POWERDOWN_FLAG;
    localparam [9:0] T1 = `OP_SKIP_ON_TIMER_ONE_REQUEST;
    localparam [9:0] T2 = `OP_SKIP_ON_TIMER_TWO_REQUEST;
    logic clock, reset_n, instr_valid, powerdown_flag, portc_pin, irq_pin, reg_write, reg_read;
    logic [9:0] instr_code;
    logic [3:0] acc, mem_nibble, set_v, reg_addr, reg_wdata;
    wire [3:0] reg_rdata_q;
    wire skip_q, irq_q;
    wire [3:0] flags; // Flags as {t2, t1, conv, ext}.
    int n_errors = 0;
    int checks_done = 0;
    row_t rows [0:21];
    skip_test_instruction_unit i_skip_test_instruction_unit (.clock(clock), .reset_n(reset_n),
        .instr_valid(instr_valid), .instr_code(instr_code), .acc(acc), .mem_nibble(mem_nibble),
        .ext_request_set(set_v[0]), .conversion_done_set(set_v[1]),
        .timer_one_request_set(set_v[2]), .timer_two_request_set(set_v[3]),
        .powerdown_flag(powerdown_flag), .portc_pin(portc_pin), .irq_pin(irq_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .skip_q(skip_q),
        .ext_request_flag_q(flags[0]), .conversion_done_flag_q(flags[1]),
        .timer_one_request_flag_q(flags[2]), .timer_two_request_flag_q(flags[3]),
        .irq_q(irq_q));
    // Free-running 10 MHz clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Compares one value and counts it.
    task check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            $display("Error %s expected %h seen %h", what, want, seen);
            n_errors++;
        end
    endtask
    task results();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One-cycle register write.
    task wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // One-cycle read; data is looked at in the only cycle it stands.
    task rd(input logic [3:0] a, input logic [3:0] want);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check("rdata", reg_rdata_q, want);
    endtask
    // Presents one word; returns just after the edge that takes it.
    task instr(input logic [9:0] c);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_code <= c;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask
    task pulse(input logic [3:0] f);
        @(posedge clock);
        set_v <= f;
        @(posedge clock);
        set_v <= 4'h0;
    endtask
    initial begin
        #(100 * 6000);
        n_errors++;
        results();
    end
    initial begin
        {reset_n, instr_valid, powerdown_flag, portc_pin, irq_pin, reg_write, reg_read} = 7'h00;
        {instr_code, acc, mem_nibble, set_v, reg_addr, reg_wdata} = 30'h0;
        rows[0] = '{EQ, 12'h000, 4'h0, 8'h55, 3'h0, 5'h10};
        rows[1] = '{EQ, 12'h000, 4'h0, 8'h54, 3'h0, 5'h00};
        rows[2] = '{EXT, 12'h000, 4'hF, 8'h00, 3'h0, 5'h1E};
        rows[3] = '{EXT, 12'h100, 4'hF, 8'h00, 3'h0, 5'h0F};
        rows[4] = '{EXT, 12'h000, 4'hE, 8'h00, 3'h0, 5'h0E};
        rows[5] = '{CNV, 12'h000, 4'hF, 8'h00, 3'h0, 5'h1D};
        rows[6] = '{CNV, 12'h040, 4'hF, 8'h00, 3'h0, 5'h0F};
        rows[7] = '{CNV, 12'h000, 4'hD, 8'h00, 3'h0, 5'h0D};
        rows[8] = '{PC, 12'h000, 4'h0, 8'h00, 3'h2, 5'h10};
        rows[9] = '{PC, 12'h000, 4'h0, 8'h00, 3'h0, 5'h00};
        rows[10] = '{PIN, 12'h000, 4'h0, 8'h00, 3'h0, 5'h10};
        rows[11] = '{PIN, 12'h000, 4'h0, 8'h00, 3'h4, 5'h00};
        rows[12] = '{PIN, 12'h004, 4'h0, 8'h00, 3'h4, 5'h10};
        rows[13] = '{PIN, 12'h004, 4'h0, 8'h00, 3'h0, 5'h00};
        rows[14] = '{PD, 12'h000, 4'h0, 8'h00, 3'h1, 5'h10};
        rows[15] = '{PD, 12'h000, 4'h0, 8'h00, 3'h0, 5'h00};
        rows[16] = '{T1, 12'h000, 4'hF, 8'h00, 3'h0, 5'h1B};
        rows[17] = '{T1, 12'h400, 4'hF, 8'h00, 3'h0, 5'h0F};
        rows[18] = '{T1, 12'h000, 4'hB, 8'h00, 3'h0, 5'h0B};
        rows[19] = '{T2, 12'h000, 4'hF, 8'h00, 3'h0, 5'h17};
        rows[20] = '{T2, 12'h800, 4'hF, 8'h00, 3'h0, 5'h0F};
        rows[21] = '{T2, 12'h000, 4'h7, 8'h00, 3'h0, 5'h07};
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        // Every register, and unmapped offsets 6 and 7, read zero after reset.
        for (int a = 0; a < 8; a++) rd(a[3:0], 4'h0);
        check("skip", skip_q, 1'b0);
        for (int i = 0; i < 22; i++) begin
            wr(`ADDR_IRQ_CONTROL_FIRST, rows[i].ctl[11:8]);
            wr(`ADDR_IRQ_CONTROL_SECOND, rows[i].ctl[7:4]);
            wr(`ADDR_IRQ_PIN_CONTROL, rows[i].ctl[3:0]);
            {acc, mem_nibble} <= rows[i].am;
            {irq_pin, portc_pin, powerdown_flag} <= rows[i].pins;
            pulse(rows[i].setf);
            // Lets the pin synchroniser settle before the test.
            repeat (3) @(posedge clock);
            instr(rows[i].code);
            check("skip", skip_q, rows[i].exp_v[4]);
            check("flags", flags, rows[i].exp_v[3:0]);
            instr(10'h000);
            wr(`ADDR_REQUEST_STATUS, 4'hF);
        end
        // A swallowed word must not clear a pending flag.
        wr(`ADDR_IRQ_CONTROL_FIRST, 4'h0);
        pulse(4'h4);
        {acc, mem_nibble} <= 8'h33;
        instr(EQ);
        // The pending skip shows in the unit state until the next word.
        rd(`ADDR_UNIT_STATE, 4'h1);
        instr(T1);
        check("skip", skip_q, 1'b0);
        check("flags", flags, 4'h4);
        // Masking, raising and clearing the interrupt.
        repeat (2) @(posedge clock);
        #1 check("irq", irq_q, 1'b0);
        wr(`ADDR_REQUEST_MASK, 4'h4);
        repeat (2) @(posedge clock);
        #1 check("irq", irq_q, 1'b1);
        rd(`ADDR_REQUEST_STATUS, 4'h4);
        rd(`ADDR_REQUEST_MASK, 4'h4);
        wr(`ADDR_REQUEST_STATUS, 4'h4);
        repeat (2) @(posedge clock);
        #1 check("irq", irq_q, 1'b0);
        // A set pulse beats a clear in the same cycle, from software or from a skip.
        fork
            pulse(4'h1);
            wr(`ADDR_REQUEST_STATUS, 4'h1);
        join
        #1 check("flags", flags, 4'h1);
        fork
            pulse(4'h1);
            instr(EXT);
        join
        check("skip", skip_q, 1'b1);
        check("flags", flags, 4'h1);
        instr(10'h000);
        wr(`ADDR_REQUEST_STATUS, 4'hF);
        wr(4'h7, 4'hF);
        rd(4'h7, 4'h0);
        wr(`ADDR_IRQ_CONTROL_FIRST, 4'hD);
        rd(`ADDR_IRQ_CONTROL_FIRST, 4'hD);
        // A reset in mid-run clears pending flags.
        pulse(4'hF);
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        #1 check("flags", flags, 4'h0);
        rd(`ADDR_IRQ_CONTROL_FIRST, 4'h0);
        results();
    end
endmodule // skip_test_instruction_unit_tb
bind skip_test_instruction_unit skip_test_asserts i_skip_test_asserts (.clock(clock),
    .reset_n(reset_n), .instr_valid(instr_valid), .instr_code(instr_code), .acc(acc),
    .mem_nibble(mem_nibble), .ext_request_set(ext_request_set),
    .timer_one_request_set(timer_one_request_set), .powerdown_flag(powerdown_flag),
    .reg_write(reg_write), .skip_q(skip_q), .ext_request_flag_q(ext_request_flag_q),
    .conversion_done_flag_q(conversion_done_flag_q),
    .timer_one_request_flag_q(timer_one_request_flag_q),
    .timer_two_request_flag_q(timer_two_request_flag_q));
